// File: core/mpura_dev.sv
// region attribute store with region read/write commands and access check
`timescale 1ns/100ps
// Overview of operation
// - software loads base in minimum-region units
// - index is identity; lower index wins
// - one kind bit selects data or instruction
// - kind one data, zero instruction
// - build option picks mask or limit form
// - mask is ones shifted by size log
// - mask runs all-ones to zero for 2GB
// - limit is next address after region
// - cacheable bit applies to data regions only
// - software sets cacheable only for memory
// - instruction perms none, supervisor, both execute
// - data perm codes decode per table
// - read command loads selected region into registers
// - write command stores region; commands write-only
// - software never sets both command bits
// - unused base/mask/limit bits written zero
// - unused index bits written zero
// - disable region by nonzero base, empty size
module mpura_dev
    import mpura_pkg::*;
#(
    parameter bit USE_LIMIT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    mpura_if.dev bus
);
    typedef struct packed {
        logic [31:0] base_reg;
        logic [31:0] attr_reg;
        mpura_region_t [MPURA_NREG-1:0] dreg;
        mpura_region_t [MPURA_NREG-1:0] ireg;
        logic hit;
        logic allow;
        logic cache;
    } mpura_state_t;

    mpura_state_t st_r;
    mpura_state_t st_nxt;

    logic kind;
    logic [MPURA_IDX_W-1:0] idx;
    mpura_region_t sel_rg;
    mpura_region_t new_rg;
    logic base_wr;
    logic attr_wr;
    logic cmd_store;
    logic cmd_fetch;
    logic [MPURA_NREG-1:0] d_match;
    logic [MPURA_NREG-1:0] i_match;
    logic [MPURA_NREG-1:0] d_ok;
    logic [MPURA_NREG-1:0] i_ok;
    logic [MPURA_NREG-1:0] d_cc;
    logic [MPURA_NREG-1:0] d_win;
    logic [MPURA_NREG-1:0] i_win;
    logic [MPURA_NREG:0] d_seen;
    logic [MPURA_NREG:0] i_seen;
    logic d_hit;
    logic i_hit;
    logic d_allow;
    logic i_allow;
    logic d_cache;
    logic [MPURA_BASE_W-1:0] a_unit;

    // data rights per code for the asking mode and direction
    function automatic logic data_ok(
        logic [2:0] pm,
        logic sup,
        logic wrt
    );
        logic ok;
        ok = 1'b0;
        case (pm)
            MPURA_P_SR: ok = sup & !wrt;
            MPURA_P_R: ok = !wrt;
            MPURA_P_SRW: ok = sup;
            MPURA_P_SRW_UR: ok = sup | !wrt;
            MPURA_P_RW: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // execute rights; codes above two grant nothing to either mode
    function automatic logic inst_ok(
        logic [2:0] pm,
        logic sup
    );
        logic ok;
        ok = 1'b0;
        case (pm)
            MPURA_P_SR: ok = sup;
            MPURA_P_R: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign kind = st_r.base_reg[MPURA_KIND_BIT];
    assign idx = st_r.base_reg[MPURA_IDX_LSB +: MPURA_IDX_W];
    assign sel_rg = kind ? st_r.dreg[idx] : st_r.ireg[idx];
    // strobes decoded once for the store and the read-back paths
    assign base_wr = bus.wr_en && bus.wr_sel == MPURA_SEL_BASE;
    assign attr_wr = bus.wr_en && bus.wr_sel == MPURA_SEL_ATTR;
    // write is tested first, so a stray double command only stores
    assign cmd_store = attr_wr && bus.wr_data[MPURA_WR_BIT];
    assign cmd_fetch = attr_wr && !bus.wr_data[MPURA_WR_BIT]
        && bus.wr_data[MPURA_RD_BIT];
    // minimum region fixed at 64 bytes; address bit 31 lies outside space
    assign a_unit = bus.chk_addr[30:MPURA_BASE_LSB];
    assign d_seen[0] = 1'b0;
    assign i_seen[0] = 1'b0;

    // match, rights and priority per region in either size form
    genvar g;
    generate
        for (g = 0; g < MPURA_NREG; g++) begin : g_match
            if (USE_LIMIT) begin : g_lim
                // limit is one past the last unit; zero disables the region
                assign d_match[g] = a_unit >= st_r.dreg[g].base
                    && {1'b0, a_unit} < st_r.dreg[g].size;
                assign i_match[g] = a_unit >= st_r.ireg[g].base
                    && {1'b0, a_unit} < st_r.ireg[g].size;
            end else begin : g_msk
                // mask zero spans the space only with base zero, so a
                // nonzero base under mask zero never matches
                assign d_match[g] = (a_unit & st_r.dreg[g].size[24:0])
                    == st_r.dreg[g].base;
                assign i_match[g] = (a_unit & st_r.ireg[g].size[24:0])
                    == st_r.ireg[g].base;
            end
            assign d_ok[g] = data_ok(st_r.dreg[g].perm, bus.chk_super,
                bus.chk_write);
            assign i_ok[g] = inst_ok(st_r.ireg[g].perm,
                bus.chk_super);
            assign d_cc[g] = st_r.dreg[g].cache;
            // a lower index seen first shadows every higher one
            assign d_win[g] = d_match[g] & !d_seen[g];
            assign i_win[g] = i_match[g] & !i_seen[g];
            assign d_seen[g+1] = d_seen[g] | d_match[g];
            assign i_seen[g+1] = i_seen[g] | i_match[g];
        end
    endgenerate

    assign d_hit = |d_match;
    assign i_hit = |i_match;
    assign d_allow = |(d_win & d_ok);
    assign i_allow = |(i_win & i_ok);
    // cacheable only ever comes from a data region
    assign d_cache = |(d_win & d_cc);

    always_comb begin
        st_nxt = st_r;
        // base comes from the register, the rest from the command word
        new_rg.base = st_r.base_reg[MPURA_BASE_LSB +: MPURA_BASE_W];
        new_rg.size = USE_LIMIT
            ? bus.wr_data[MPURA_SZ_LSB +: MPURA_SZ_W]
            : {1'b0, bus.wr_data[MPURA_SZ_LSB +: MPURA_BASE_W]};
        new_rg.cache = bus.wr_data[MPURA_CACHE_BIT] & kind;
        new_rg.perm = bus.wr_data[MPURA_PERM_LSB +: 3];
        if (base_wr) begin
            st_nxt.base_reg = bus.wr_data;
        end
        if (attr_wr) begin
            // command bits are not kept, so they read back as zero
            st_nxt.attr_reg = {bus.wr_data[31:MPURA_CACHE_BIT],
                bus.wr_data[MPURA_PERM_LSB +: 3], 2'b00};
        end
        if (cmd_store) begin
            if (kind) begin
                st_nxt.dreg[idx] = new_rg;
            end else begin
                st_nxt.ireg[idx] = new_rg;
            end
        end
        if (cmd_fetch) begin
            // a read replaces only the base field; kind and index stay
            st_nxt.base_reg[MPURA_BASE_LSB +: MPURA_BASE_W] =
                sel_rg.base;
            st_nxt.attr_reg = {sel_rg.size,
                sel_rg.cache, sel_rg.perm, 2'b00};
        end
        // no match in the asked kind gives no hit and no rights
        st_nxt.hit = bus.chk_data ? d_hit : i_hit;
        st_nxt.allow = bus.chk_data ? d_allow : i_allow;
        st_nxt.cache = bus.chk_data & d_cache;
    end

    // reset wins over the enable, so a frozen block still clears
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // the query answer lags the request by one cycle
    assign bus.base_rd = st_r.base_reg;
    assign bus.attr_rd = st_r.attr_reg;
    assign bus.chk_hit = st_r.hit;
    assign bus.chk_allow = st_r.allow;
    assign bus.chk_cache = st_r.cache;
endmodule

// File: core/mpura_host.sv
// core-side control-register writer and access request driver
`timescale 1ns/100ps
module mpura_host
    import mpura_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_wr,
    input wire logic [1:0] req_sel,
    input wire logic [31:0] req_data,
    input wire logic [31:0] req_addr,
    input wire logic req_data_acc,
    input wire logic req_super,
    input wire logic req_write,
    output logic [31:0] base_val,
    output logic [31:0] attr_val,
    output logic acc_hit,
    output logic acc_allow,
    output logic acc_cache,
    mpura_if.host bus
);
    typedef struct packed {
        logic wr;
        logic [1:0] sel;
        logic [31:0] data;
        logic [31:0] addr;
        logic dacc;
        logic sup;
        logic wrt;
        logic [31:0] base_v;
        logic [31:0] attr_v;
        logic hit;
        logic allow;
        logic cache;
    } mpura_hstate_t;

    mpura_hstate_t st_r;
    mpura_hstate_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = req_wr;
        st_nxt.sel = req_sel;
        // never both command bits; write wins when both are asked
        st_nxt.data = (req_data[MPURA_WR_BIT] && req_sel == MPURA_SEL_ATTR)
            ? (req_data & ~(32'h1 << MPURA_RD_BIT)) : req_data;
        st_nxt.addr = req_addr;
        st_nxt.dacc = req_data_acc;
        st_nxt.sup = req_super;
        st_nxt.wrt = req_write;
        st_nxt.base_v = bus.base_rd;
        st_nxt.attr_v = bus.attr_rd;
        st_nxt.hit = bus.chk_hit;
        st_nxt.allow = bus.chk_allow;
        st_nxt.cache = bus.chk_cache;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign bus.wr_en = st_r.wr;
    assign bus.wr_sel = st_r.sel;
    assign bus.wr_data = st_r.data;
    assign bus.chk_addr = st_r.addr;
    assign bus.chk_data = st_r.dacc;
    assign bus.chk_super = st_r.sup;
    assign bus.chk_write = st_r.wrt;
    assign base_val = st_r.base_v;
    assign attr_val = st_r.attr_v;
    assign acc_hit = st_r.hit;
    assign acc_allow = st_r.allow;
    assign acc_cache = st_r.cache;
endmodule

// File: core/mpura_if.sv
// control-register link between the core and the region attribute logic
`timescale 1ns/100ps
interface mpura_if;
    import mpura_pkg::*;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [31:0] wr_data;
    logic [31:0] base_rd;
    logic [31:0] attr_rd;
    logic [31:0] chk_addr;
    logic chk_data;
    logic chk_super;
    logic chk_write;
    logic chk_hit;
    logic chk_allow;
    logic chk_cache;
    modport dev (input wr_en, wr_sel, wr_data, chk_addr, chk_data,
        chk_super, chk_write, output base_rd, attr_rd, chk_hit,
        chk_allow, chk_cache);
    modport host (output wr_en, wr_sel, wr_data, chk_addr, chk_data,
        chk_super, chk_write, input base_rd, attr_rd, chk_hit,
        chk_allow, chk_cache);
endinterface

// File: core/mpura_pkg.sv
// shared constants and types for the region attribute logic
package mpura_pkg;
    localparam int unsigned MPURA_NREG = 8;
    localparam int unsigned MPURA_IDX_W = 3;
    localparam int unsigned MPURA_BASE_W = 25;
    localparam int unsigned MPURA_SZ_W = 26;
    // control register selects on the core's control port
    localparam logic [1:0] MPURA_SEL_BASE = 2'h1;
    localparam logic [1:0] MPURA_SEL_ATTR = 2'h2;
    // base register layout
    localparam int unsigned MPURA_KIND_BIT = 0;
    localparam int unsigned MPURA_IDX_LSB = 1;
    localparam int unsigned MPURA_BASE_LSB = 6;
    // attribute register layout
    localparam int unsigned MPURA_WR_BIT = 0;
    localparam int unsigned MPURA_RD_BIT = 1;
    localparam int unsigned MPURA_PERM_LSB = 2;
    localparam int unsigned MPURA_CACHE_BIT = 5;
    localparam int unsigned MPURA_SZ_LSB = 6;
    localparam logic [31:0] MPURA_RESET_VAL = 32'h0000_0000;
    // mask encodings
    localparam logic [24:0] MPURA_MASK_ONES = 25'h1ff_ffff;
    localparam logic [24:0] MPURA_MASK_1G = 25'h100_0000;
    localparam logic [24:0] MPURA_MASK_2G = 25'h000_0000;
    // permission codes
    localparam logic [2:0] MPURA_P_NONE = 3'h0;
    localparam logic [2:0] MPURA_P_SR = 3'h1;
    localparam logic [2:0] MPURA_P_R = 3'h2;
    localparam logic [2:0] MPURA_P_SRW = 3'h4;
    localparam logic [2:0] MPURA_P_SRW_UR = 3'h5;
    localparam logic [2:0] MPURA_P_RW = 3'h6;

    typedef struct packed {
        logic [MPURA_BASE_W-1:0] base;
        logic [MPURA_SZ_W-1:0] size;
        logic cache;
        logic [2:0] perm;
    } mpura_region_t;
endpackage

// File: verif/mpura_monitor.sv
// assertion checker on the core to region logic link
`timescale 1ns/100ps
module mpura_monitor
    import mpura_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] base_rd,
    input wire logic [31:0] attr_rd,
    input wire logic chk_data,
    input wire logic chk_hit,
    input wire logic chk_allow,
    input wire logic chk_cache
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic aw = wr_en && wr_sel == MPURA_SEL_ATTR;
    wire logic bw = wr_en && wr_sel == MPURA_SEL_BASE;
    rst_zero_a: assert property (disable iff (1'b0)
        !rst_n |=> base_rd == 32'h0 && attr_rd == 32'h0)
        else $error("registers not zero after reset");
    cmd_bits_zero_a: assert property (attr_rd[1:0] == 2'h0)
        else $error("command bits read back set");
    attr_store_a: assert property (aw && wr_data[0] |=>
        {attr_rd[31:2], 2'h0} == ($past(wr_data) & 32'hffff_fffc))
        else $error("attribute write not kept");
    base_store_a: assert property (bw |=>
        (base_rd & 32'h7fff_ffcf) == ($past(wr_data) & 32'h7fff_ffcf))
        else $error("base write not kept");
    read_keeps_sel_a: assert property (aw && wr_data[1] && !wr_data[0]
        |=> $stable(base_rd[3:0]))
        else $error("region read changed kind or index");
    idle_hold_a: assert property (!$past(wr_en) |->
        $stable(base_rd) && $stable(attr_rd))
        else $error("registers moved without a write");
    cache_data_a: assert property (chk_cache |-> $past(chk_data))
        else $error("cacheable on instruction query");
    allow_hit_a: assert property (chk_allow |-> chk_hit)
        else $error("allow without a matching region");
    cmd_excl_a: assert property (aw |-> !(wr_data[0] && wr_data[1]))
        else $error("both region commands issued together");
    cover property (aw && wr_data[0]);
    cover property (aw && wr_data[1]);
    cover property (chk_allow && chk_cache);
endmodule

// File: verif/test_mpu_region_attribute_logic.sv
// self-checking bench for both ends of the region link
`timescale 1ns/100ps
module test_mpu_region_attribute_logic;
    import mpura_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_wr = 1'b0;
    logic [1:0] req_sel = 2'h0;
    logic [31:0] req_data = 32'h0;
    logic [31:0] req_addr = 32'h0;
    logic [2:0] dsw = 3'h0;
    logic [31:0] base_val;
    logic [31:0] attr_val;
    logic acc_hit;
    logic acc_allow;
    logic acc_cache;
    logic [2:0] p;
    int fail_count = 0;
    int n_checks = 0;
    // row: address, {data, super, write}, {hit, allow, cache}
    localparam logic [37:0] ROWS [10] = '{
        {32'h0002_1000, 3'h6, 3'h4}, {32'h0002_1040, 3'h5, 3'h7},
        {32'h0000_1004, 3'h4, 3'h6}, {32'h0000_1004, 3'h5, 3'h4},
        {32'h0000_1004, 3'h7, 3'h6}, {32'h0000_1004, 3'h0, 3'h4},
        {32'h0000_1004, 3'h2, 3'h6}, {32'h0000_3000, 3'h2, 3'h4},
        {32'h8000_1004, 3'h7, 3'h6}, {32'h0000_3000, 3'h6, 3'h7}};
    localparam logic [2:0] DCODE [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    mpura_if bus ();
    always #50 ref_clk = ~ref_clk;
    mpura_host u_mpura_host (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .req_wr(req_wr), .req_sel(req_sel),
        .req_data(req_data), .req_addr(req_addr), .req_data_acc(dsw[2]),
        .req_super(dsw[1]), .req_write(dsw[0]), .base_val(base_val),
        .attr_val(attr_val), .acc_hit(acc_hit), .acc_allow(acc_allow),
        .acc_cache(acc_cache), .bus(bus));
    mpura_dev #(.USE_LIMIT(1'b0)) u_mpura_dev (.ref_clk(ref_clk),
        .rst_n(rst_n), .clk_en(clk_en), .bus(bus));
    mpura_monitor u_mpura_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
        .wr_en(bus.wr_en), .wr_sel(bus.wr_sel), .wr_data(bus.wr_data),
        .base_rd(bus.base_rd), .attr_rd(bus.attr_rd),
        .chk_data(bus.chk_data), .chk_hit(bus.chk_hit),
        .chk_allow(bus.chk_allow), .chk_cache(bus.chk_cache));
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // leaves the strobe high so two writes can go back to back
    task automatic wr(logic [1:0] s, logic [31:0] d);
        req_wr = 1'b1;
        req_sel = s;
        req_data = d;
        tick(1);
    endtask
    task automatic put(logic k, logic [2:0] i, logic [24:0] b,
        logic [24:0] m, logic c, logic [2:0] pm);
        wr(MPURA_SEL_BASE, {1'b0, b, 2'h0, i, k});
        wr(MPURA_SEL_ATTR, {1'b0, m, c, pm, 2'h1});
        req_wr = 1'b0;
        tick(1);
    endtask
    task automatic ask(logic [31:0] a, logic [2:0] q, logic [2:0] e);
        req_addr = a;
        dsw = q;
        tick(4);
        chk("hit", {31'h0, e[2]}, {31'h0, acc_hit});
        chk("allow", {31'h0, e[1]}, {31'h0, acc_allow});
        chk("cache", {31'h0, e[0]}, {31'h0, acc_cache});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        rst_n = 1'b1;
        tick(1);
        put(1'b1, 3'h0, 25'h840, MPURA_MASK_ONES, 1'b0, MPURA_P_NONE);
        put(1'b1, 3'h1, 25'h1, MPURA_MASK_2G, 1'b0, MPURA_P_RW);
        put(1'b1, 3'h3, 25'h0, MPURA_MASK_2G, 1'b1, MPURA_P_RW);
        put(1'b1, 3'h2, 25'h40, 25'h1ff_ffc0, 1'b0, MPURA_P_SRW_UR);
        put(1'b0, 3'h0, 25'h40, 25'h1ff_ffc0, 1'b1, MPURA_P_SR);
        foreach (ROWS[i]) ask(ROWS[i][37:6], ROWS[i][5:3], ROWS[i][2:0]);
        $display("test rows done");
        foreach (DCODE[j]) begin
            p = DCODE[j];
            put(1'b1, 3'h2, 25'h40, 25'h1ff_ffc0, 1'b0, p);
            ask(32'h1004, 3'h6, {1'b1, p != 3'h0, 1'b0});
            ask(32'h1004, 3'h7, {1'b1, p[2], 1'b0});
            ask(32'h1004, 3'h4, {1'b1, p == 3'h2 || p[2:1] == 2'h3
                || p == 3'h5, 1'b0});
            ask(32'h1004, 3'h5, {1'b1, p == 3'h6, 1'b0});
        end
        for (int k = 0; k < 3; k++) begin
            p = 3'(k);
            put(1'b0, 3'h0, 25'h40, 25'h1ff_ffc0, 1'b1, p);
            ask(32'h1004, 3'h2, {1'b1, p != 3'h0, 1'b0});
            ask(32'h1004, 3'h0, {1'b1, p == 3'h2, 1'b0});
        end
        $display("test permission codes done");
        put(1'b1, 3'h5, 25'h123, 25'h1ff_ff00, 1'b1, MPURA_P_SRW_UR);
        tick(3);
        chk("attr", 32'h7fff_c034, attr_val);
        wr(MPURA_SEL_BASE, 32'h0000_000b);
        wr(MPURA_SEL_ATTR, 32'h0000_0002);
        req_wr = 1'b0;
        tick(4);
        chk("rd base", 32'h0000_48cb, base_val);
        chk("rd attr", 32'h7fff_c034, attr_val);
        wr(2'h0, 32'hffff_ffff);
        req_wr = 1'b0;
        tick(4);
        chk("refused", 32'h7fff_c034, attr_val);
        wr(MPURA_SEL_ATTR, 32'h7fff_ffcb);
        req_wr = 1'b0;
        tick(4);
        chk("both cmd", 32'h7fff_ffc8, attr_val);
        clk_en = 1'b0;
        wr(MPURA_SEL_BASE, 32'h0000_00ff);
        req_wr = 1'b0;
        tick(4);
        clk_en = 1'b1;
        tick(4);
        chk("frozen base", 32'h0000_48cb, base_val);
        $display("test region read done");
        rst_n = 1'b0;
        tick(20);
        chk("rst base", 32'h0, base_val);
        chk("rst attr", 32'h0, attr_val);
        rst_n = 1'b1;
        tick(1);
        ask(32'h1004, 3'h6, 3'h4);
        $display("test second reset done");
        wrap_up();
    end
endmodule
